// [core/srl_pkg.sv]
// package of constants, offsets and states for the serial register port
package srl_pkg;
   // clock and timing
   localparam int          SYS_PERIOD_NS   = 10;        // clk_sys period
   localparam int          UVD_DELAY_NS    = 50000;     // undervoltage detection delay, plain default
   localparam int          UVD_CYCLES_DEF  = (UVD_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int          UVD_CNT_W       = 20;        // width of the undervoltage delay counter

   // frame bit counts
   localparam logic [5:0]  BITS_BYTE       = 6'h08;
   localparam logic [5:0]  BITS_16         = 6'h10;
   localparam logic [5:0]  BITS_24         = 6'h18;
   localparam logic [5:0]  BITS_32         = 6'h20;
   localparam logic [5:0]  BITS_MAX        = 6'h3f;     // counter saturates here

   // register offsets
   localparam logic [6:0]  ADDR_MAIN_STAT  = 7'h03;
   localparam logic [6:0]  ADDR_SYS_EN     = 7'h04;
   localparam logic [6:0]  ADDR_SCRATCH0   = 7'h06;
   localparam logic [6:0]  ADDR_SCRATCH3   = 7'h09;
   localparam logic [6:0]  ADDR_LOCK       = 7'h0a;
   localparam logic [6:0]  ADDR_TRX_EN     = 7'h23;
   localparam logic [6:0]  ADDR_WAKE_EN    = 7'h4c;
   localparam logic [6:0]  ADDR_SYS_EVT    = 7'h61;
   localparam logic [6:0]  ADDR_TRX_EVT    = 7'h63;

   // field positions
   localparam int          POS_FSS         = 7;         // forced sleep status in main status
   localparam int          POS_SF_EN       = 1;         // serial failure enable in system enable
   localparam int          POS_SF_FLAG     = 1;         // serial failure flag in system events
   localparam int          POS_CF_FLAG     = 1;         // can failure flag in transceiver events
   localparam int          POS_BS_EN       = 4;         // bus silence enable
   localparam int          POS_CF_EN       = 1;         // can failure enable
   localparam int          POS_CW_EN       = 0;         // can wake-up enable
   localparam int          POS_WR_EN       = 1;         // wake rising edge enable
   localparam int          POS_WF_EN       = 0;         // wake falling edge enable

   // writable masks, reserved bits read zero
   localparam logic [7:0]  MASK_LOCK       = 8'h7f;
   localparam logic [7:0]  MASK_TRX_EN     = 8'h13;
   localparam logic [7:0]  MASK_WAKE_EN    = 8'h03;
   localparam logic [7:0]  MASK_SYS_EN     = 8'h02;

   // reset values
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [1:0]  CAN_MODE_ACTIVE = 2'h1;      // mode field value for undervoltage failure

   // frame state machine
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_FRAME  = 3'b010,
      ST_COMMIT = 3'b100
   } srl_state_e;
endpackage

// [core/srl_sync.sv]
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module srl_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // asynchronous input and filtered output
   input  wire logic d,
   output logic      q
);
   logic s1;   // first stage, read only by s2
   logic s2;   // second stage
   logic s3;   // third stage

   // shift chain; output follows once stages two and three agree
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         q  <= RST_VAL;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q <= s3;
         end
      end
   end
endmodule

// [core/srl_port.sv]
// serial register port with write locks, scratch bytes and undervoltage sleep effects
//
// What this block does
// - sample on falling edge, launch on rising
// - flag zero writes, flag one reads only
// - longer frames auto-increment the register address
// - addressed contents shift out, full duplex
// - unmapped or overflowing writes silently ignored
// - wrong write bit count aborts, flags failure when enabled
// - read past 32 bits echoes input
// - output driven only while select low
// - transceiver enables at bits 4, 1, 0
// - wake edge enables at bits 1, 0
// - can failure captured only when active
// - lock bit blocks serial writes only
// - lock bits 6,5,4 guard upper areas
// - lock bits 3..0 guard lower areas
// - four scratch bytes at 0x06 to 0x09
// - lasting undervoltage forces sleep
// - forced sleep clears captured event flags
// - forced sleep sets wake enables
// - forced sleep clears partial network settings
// - forced sleep sets its status bit
// - event flags cleared by writing one
// - serial failure captured only when enabled
`timescale 1ns/1ps
module srl_port
   import srl_pkg::*;
#(
   parameter int UVD_CYCLES = UVD_CYCLES_DEF
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // serial pins
   input  wire logic       serial_select_n,
   input  wire logic       sclk,
   input  wire logic       sdi,
   output logic            sdo,
   output logic            sdo_oe,
   // supply monitors and transceiver state
   input  wire logic       vcc_uv,
   input  wire logic       vio_uv,
   input  wire logic       normal_mode,
   input  wire logic       trx_active,
   input  wire logic       txd_dominant_timeout,
   input  wire logic [1:0] can_mode_field,
   input  wire logic       normal_sleep_entry,
   // configuration and status toward the rest of the chip
   output logic            bus_silence_event_enable,
   output logic            can_failure_event_enable,
   output logic            can_wakeup_event_enable,
   output logic            wake_rising_edge_enable,
   output logic            wake_falling_edge_enable,
   output logic            can_failure_event_flag,
   output logic            serial_failure_flag,
   output logic            forced_sleep_status,
   output logic            uv_sleep_request,
   output logic            event_flags_clear,
   output logic            partial_network_clear
);
   // synchronised pins
   logic              csn_q;         // filtered select
   logic              sclk_q;        // filtered serial clock
   logic              sdi_q;         // filtered data in
   logic              vcc_uv_q;      // filtered supply monitor
   logic              vio_uv_q;      // filtered logic supply monitor
   logic              csn_d;         // previous select
   logic              sclk_d;        // previous serial clock

   // frame state
   srl_state_e        state;
   logic [5:0]        bit_cnt;       // bits sampled this frame, saturating
   logic [6:0]        rx_sh;         // partial byte being received
   logic [6:0]        base_addr;     // address from first byte
   logic              read_only;     // read-only flag from first byte
   logic [7:0]        wbuf [0:2];    // data bytes awaiting commit
   logic [7:0]        tx_byte;       // byte being returned
   logic [1:0]        commit_idx;    // slot being committed
   logic [1:0]        commit_n;      // data bytes in the frame
   logic              aborted;       // frame dropped by forced sleep

   // registers
   logic [7:0]        scratch [0:3]; // user scratch bytes
   logic [7:0]        lock_bits;     // write protect areas
   logic              sf_enable;     // serial failure enable

   // undervoltage timing
   logic [UVD_CNT_W-1:0] uv_cnt;     // cycles of lasting undervoltage
   logic              uv_done;       // forced sleep already issued for this episode

   // events
   logic              sclk_fall;
   logic              sclk_rise;
   logic              csn_fall;
   logic              csn_rise;
   logic              uv_force;
   logic [5:0]        next_cnt;
   logic [7:0]        new_byte;
   logic              wr_en;
   logic [7:0]        wr_addr;
   logic [7:0]        wr_data;
   logic              frame_fail;

   // pin synchronisers
   srl_sync #(.RST_VAL(1'b1)) u_sync_csn (.clk_sys(clk_sys), .nrst(nrst), .d(serial_select_n), .q(csn_q));
   srl_sync #(.RST_VAL(1'b0)) u_sync_sck (.clk_sys(clk_sys), .nrst(nrst), .d(sclk), .q(sclk_q));
   srl_sync #(.RST_VAL(1'b0)) u_sync_sdi (.clk_sys(clk_sys), .nrst(nrst), .d(sdi), .q(sdi_q));
   srl_sync #(.RST_VAL(1'b0)) u_sync_vcc (.clk_sys(clk_sys), .nrst(nrst), .d(vcc_uv), .q(vcc_uv_q));
   srl_sync #(.RST_VAL(1'b0)) u_sync_vio (.clk_sys(clk_sys), .nrst(nrst), .d(vio_uv), .q(vio_uv_q));

   // edge history of filtered pins
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         csn_d  <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         csn_d  <= csn_q;
         sclk_d <= sclk_q;
      end
   end

   assign csn_fall  = csn_d & ~csn_q;
   assign csn_rise  = ~csn_d & csn_q;
   assign sclk_fall = sclk_d & ~sclk_q & ~csn_q;
   assign sclk_rise = ~sclk_d & sclk_q & ~csn_q;
   assign next_cnt  = (bit_cnt == BITS_MAX) ? BITS_MAX : bit_cnt + 6'h01;
   assign new_byte  = {rx_sh, sdi_q};

   // lock area check for a serial write address
   function automatic logic area_locked(input logic [6:0] a, input logic [7:0] lk);
      logic r;
      r = 1'b0;
      if (a >= 7'h68 && a <= 7'h6f) begin
         r = lk[6];
      end else if (a >= 7'h50 && a <= 7'h5f) begin
         r = lk[5];
      end else if (a >= 7'h40 && a <= 7'h4f) begin
         r = lk[4];
      end else if (a >= 7'h30 && a <= 7'h3f) begin
         r = lk[3];
      end else if (a >= 7'h20 && a <= 7'h2f) begin
         r = lk[2];
      end else if (a >= 7'h10 && a <= 7'h1f) begin
         r = lk[1];
      end else if (a >= ADDR_SCRATCH0 && a <= ADDR_SCRATCH3) begin
         r = lk[0];
      end
      return r;
   endfunction

   // read value of an address; unmapped and overflow read zero
   function automatic logic [7:0] read_reg(input logic [7:0] a);
      logic [7:0] v;
      v = RST_BYTE;
      if (a[7]) begin
         v = RST_BYTE;
      end else if (a[6:0] == ADDR_MAIN_STAT) begin
         v[POS_FSS] = forced_sleep_status;
      end else if (a[6:0] == ADDR_SYS_EN) begin
         v[POS_SF_EN] = sf_enable;
      end else if (a[6:0] >= ADDR_SCRATCH0 && a[6:0] <= ADDR_SCRATCH3) begin
         v = scratch[a[1:0] - 2'h2];
      end else if (a[6:0] == ADDR_LOCK) begin
         v = lock_bits & MASK_LOCK;
      end else if (a[6:0] == ADDR_TRX_EN) begin
         v[POS_BS_EN] = bus_silence_event_enable;
         v[POS_CF_EN] = can_failure_event_enable;
         v[POS_CW_EN] = can_wakeup_event_enable;
      end else if (a[6:0] == ADDR_WAKE_EN) begin
         v[POS_WR_EN] = wake_rising_edge_enable;
         v[POS_WF_EN] = wake_falling_edge_enable;
      end else if (a[6:0] == ADDR_SYS_EVT) begin
         v[POS_SF_FLAG] = serial_failure_flag;
      end else if (a[6:0] == ADDR_TRX_EVT) begin
         v[POS_CF_FLAG] = can_failure_event_flag;
      end
      return v;
   endfunction

   // frame state machine, bit sampling and commit sequencing
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state      <= ST_IDLE;
         bit_cnt    <= 6'h00;
         rx_sh      <= 7'h00;
         base_addr  <= 7'h00;
         read_only  <= 1'b1;
         tx_byte    <= RST_BYTE;
         commit_idx <= 2'h0;
         commit_n   <= 2'h0;
         aborted    <= 1'b0;
         wbuf[0]    <= RST_BYTE;
         wbuf[1]    <= RST_BYTE;
         wbuf[2]    <= RST_BYTE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (csn_fall) begin
                  state   <= ST_FRAME;
                  bit_cnt <= 6'h00;
                  tx_byte <= RST_BYTE;
                  aborted <= uv_done;
               end
            end
            ST_FRAME: begin
               if (uv_force) begin
                  aborted <= 1'b1;                          // automatic sleep beats the transfer
               end
               if (csn_rise) begin
                  if (!read_only && !aborted && !uv_force &&
                      (bit_cnt == BITS_16 || bit_cnt == BITS_24 || bit_cnt == BITS_32)) begin
                     state      <= ST_COMMIT;
                     commit_idx <= 2'h0;
                     commit_n   <= bit_cnt[4:3] - 2'h1;
                  end else begin
                     state <= ST_IDLE;
                  end
               end else if (sclk_fall) begin
                  bit_cnt <= next_cnt;
                  rx_sh   <= new_byte[6:0];
                  if (next_cnt == BITS_BYTE) begin
                     base_addr <= new_byte[7:1];
                     read_only <= new_byte[0];
                     tx_byte   <= read_reg({1'b0, new_byte[7:1]});
                  end else if (next_cnt[2:0] == 3'h0 && next_cnt <= BITS_32) begin
                     if (!read_only) begin
                        wbuf[next_cnt[4:3] - 2'h2] <= new_byte;
                     end
                     tx_byte <= read_reg({1'b0, base_addr} + {5'h00, next_cnt[4:3]} - 8'h01);
                  end
               end
            end
            ST_COMMIT: begin
               commit_idx <= commit_idx + 2'h1;
               if (commit_idx + 2'h1 >= commit_n) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // one write port per cycle during commit
   assign wr_addr    = {1'b0, base_addr} + {6'h00, commit_idx};
   assign wr_data    = wbuf[commit_idx];
   assign wr_en      = (state == ST_COMMIT) && !wr_addr[7] &&
                       !area_locked(wr_addr[6:0], lock_bits) && !uv_force;
   assign frame_fail = (state == ST_FRAME) && csn_rise && !read_only && !aborted &&
                       !(bit_cnt == BITS_16 || bit_cnt == BITS_24 || bit_cnt == BITS_32);

   // serial output: launch on rising edge, echo past 32 read bits
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= ~csn_q;
         if (csn_q) begin
            sdo <= 1'b0;
         end else if (sclk_rise) begin
            if (read_only && bit_cnt >= BITS_32) begin
               sdo <= sdi_q;
            end else if (bit_cnt < BITS_32) begin
               sdo <= tx_byte[3'h7 - bit_cnt[2:0]];
            end
         end
      end
   end

   // scratch bytes and lock register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         scratch[0] <= RST_BYTE;
         scratch[1] <= RST_BYTE;
         scratch[2] <= RST_BYTE;
         scratch[3] <= RST_BYTE;
         lock_bits  <= RST_BYTE;
         sf_enable  <= 1'b0;
      end else if (wr_en) begin
         if (wr_addr[6:0] >= ADDR_SCRATCH0 && wr_addr[6:0] <= ADDR_SCRATCH3) begin
            scratch[wr_addr[1:0] - 2'h2] <= wr_data;
         end else if (wr_addr[6:0] == ADDR_LOCK) begin
            lock_bits <= wr_data & MASK_LOCK;
         end else if (wr_addr[6:0] == ADDR_SYS_EN) begin
            sf_enable <= wr_data[POS_SF_EN];
         end
      end
   end

   // event enables; forced sleep overrides the wake enables
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus_silence_event_enable <= 1'b0;
         can_failure_event_enable <= 1'b0;
         can_wakeup_event_enable  <= 1'b0;
         wake_rising_edge_enable  <= 1'b0;
         wake_falling_edge_enable <= 1'b0;
      end else if (uv_force) begin
         can_wakeup_event_enable  <= 1'b1;
         wake_rising_edge_enable  <= 1'b1;
         wake_falling_edge_enable <= 1'b1;
      end else if (wr_en && wr_addr[6:0] == ADDR_TRX_EN) begin
         bus_silence_event_enable <= wr_data[POS_BS_EN];
         can_failure_event_enable <= wr_data[POS_CF_EN];
         can_wakeup_event_enable  <= wr_data[POS_CW_EN];
      end else if (wr_en && wr_addr[6:0] == ADDR_WAKE_EN) begin
         wake_rising_edge_enable  <= wr_data[POS_WR_EN];
         wake_falling_edge_enable <= wr_data[POS_WF_EN];
      end
   end

   // captured event flags: forced sleep clear, then set, then write-one clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_failure_flag    <= 1'b0;
         can_failure_event_flag <= 1'b0;
      end else begin
         if (uv_force) begin
            serial_failure_flag <= 1'b0;
         end else if (frame_fail && sf_enable) begin
            serial_failure_flag <= 1'b1;
         end else if (state == ST_COMMIT && !wr_addr[7] && wr_addr[6:0] == ADDR_SYS_EVT &&
                      wr_data[POS_SF_FLAG]) begin
            serial_failure_flag <= 1'b0;
         end
         if (uv_force) begin
            can_failure_event_flag <= 1'b0;
         end else if (can_failure_event_enable && normal_mode && trx_active &&
                      (txd_dominant_timeout || (vcc_uv_q && can_mode_field == CAN_MODE_ACTIVE))) begin
            can_failure_event_flag <= 1'b1;
         end else if (state == ST_COMMIT && !wr_addr[7] && wr_addr[6:0] == ADDR_TRX_EVT &&
                      wr_data[POS_CF_FLAG]) begin
            can_failure_event_flag <= 1'b0;
         end
      end
   end

   // undervoltage delay counter, one forced sleep per episode
   assign uv_force = (vcc_uv_q || vio_uv_q) && !uv_done &&
                     (uv_cnt >= UVD_CNT_W'(UVD_CYCLES - 1));

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         uv_cnt  <= '0;
         uv_done <= 1'b0;
      end else if (!(vcc_uv_q || vio_uv_q)) begin
         uv_cnt  <= '0;
         uv_done <= 1'b0;
      end else if (uv_force) begin
         uv_done <= 1'b1;
      end else if (!uv_done) begin
         uv_cnt  <= uv_cnt + 1'b1;
      end
   end

   // forced sleep status and pulses toward mode and partial network logic
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         forced_sleep_status   <= 1'b0;
         uv_sleep_request      <= 1'b0;
         event_flags_clear     <= 1'b0;
         partial_network_clear <= 1'b0;
      end else begin
         uv_sleep_request      <= uv_force;
         event_flags_clear     <= uv_force;
         partial_network_clear <= uv_force;
         if (uv_force) begin
            forced_sleep_status <= 1'b1;
         end else if (normal_sleep_entry) begin
            forced_sleep_status <= 1'b0;
         end
      end
   end
endmodule

// [tb/srl_monitor.sv]
// checker of the serial register port outputs
`timescale 1ns/1ps
module srl_monitor
   import srl_pkg::*;
#(
   parameter int UVD_CYCLES = UVD_CYCLES_DEF
) (
   // watched ports
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic serial_select_n,
   input wire logic sdo_oe,
   input wire logic vcc_uv,
   input wire logic vio_uv,
   input wire logic normal_mode,
   input wire logic trx_active,
   input wire logic bus_silence_event_enable,
   input wire logic can_failure_event_enable,
   input wire logic can_wakeup_event_enable,
   input wire logic wake_rising_edge_enable,
   input wire logic wake_falling_edge_enable,
   input wire logic can_failure_event_flag,
   input wire logic serial_failure_flag,
   input wire logic forced_sleep_status,
   input wire logic uv_sleep_request,
   input wire logic event_flags_clear,
   input wire logic partial_network_clear
);
   wire uv_any = vcc_uv | vio_uv;   // either supply low
   wire cf_ok  = can_failure_event_enable & normal_mode & trx_active;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_oe_idle_off: assert property (serial_select_n [*8] |-> !sdo_oe) else $error("sdo driven unselected");
   a_oe_sel_on: assert property (!serial_select_n [*8] |-> sdo_oe) else $error("sdo not driven");
   a_uv_once_pulse: assert property (uv_sleep_request |=> !uv_sleep_request [*8]) else $error("sleep pulse");
   a_uv_needs_supply: assert property (uv_sleep_request |-> $past(uv_any, 8)) else $error("sleep no uv");
   a_uv_wake_enables: assert property (uv_sleep_request |-> ##[0:1] (forced_sleep_status
      && can_wakeup_event_enable && wake_rising_edge_enable && wake_falling_edge_enable)) else $error("sleep settings");
   a_uv_flags_drop: assert property (uv_sleep_request |-> ##[0:1]
      (!serial_failure_flag && !can_failure_event_flag)) else $error("flags kept");
   a_uv_pulses: assert property (uv_sleep_request == event_flags_clear &&
      uv_sleep_request == partial_network_clear) else $error("sleep pulses apart");
   a_cf_cause: assert property ($rose(can_failure_event_flag) |-> $past(cf_ok)) else $error("cf no cause");
   a_en_commit_idle: assert property ($changed(bus_silence_event_enable) |-> serial_select_n)
      else $error("write mid frame");
   c_uv: cover property (uv_sleep_request);
   c_sf: cover property ($rose(serial_failure_flag));
   c_cf: cover property ($rose(can_failure_event_flag));
endmodule
bind srl_port srl_monitor #(.UVD_CYCLES(UVD_CYCLES)) mon (.clk_sys, .nrst, .serial_select_n, .sdo_oe, .vcc_uv,
   .vio_uv, .normal_mode, .trx_active, .bus_silence_event_enable, .can_failure_event_enable,
   .can_wakeup_event_enable, .wake_rising_edge_enable, .wake_falling_edge_enable, .can_failure_event_flag,
   .serial_failure_flag, .forced_sleep_status, .uv_sleep_request, .event_flags_clear, .partial_network_clear);

// [tb/srl_master.sv]
// serial bus master model, link clock 125 ns on average
`timescale 1ns/1ps
module srl_master (
   // clock and serial lines
   input  wire logic clk_sys,
   input  wire logic sdo,
   output logic      serial_select_n = 1'b1,
   output logic      sclk = 1'b0,
   output logic      sdi = 1'b0
);
   // one frame of n bits, first bit from d[n-1]
   task automatic xfer(input int n, input logic [39:0] d, output logic [39:0] q);
      q = '0;
      serial_select_n <= 1'b0;   // frame opens
      repeat (7) @(posedge clk_sys);
      for (int i = n - 1; i >= 0; i--) begin
         sclk <= 1'b1;
         sdi <= d[i];   // launch on rise, msb first
         repeat (6) @(posedge clk_sys);
         sclk <= 1'b0;
         q[i] = sdo;   // sample at fall
         repeat (6 + i % 2) @(posedge clk_sys);
      end
      serial_select_n <= 1'b1;
      sdi <= ~sdi;   // released line shows no stale value
      repeat (12) @(posedge clk_sys);
   endtask
endmodule

// [tb/tb.sv]
// self-checking bench of the serial register port
`timescale 1ns/1ps
module tb;
   import srl_pkg::*;
   logic       clk_sys, nrst, vcc_uv, vio_uv, normal_mode, trx_active, txd_dominant_timeout, normal_sleep_entry;
   logic       serial_select_n, sclk, sdi, sdo, sdo_oe, bus_silence_event_enable, can_failure_event_enable;
   logic       can_wakeup_event_enable, wake_rising_edge_enable, wake_falling_edge_enable, can_failure_event_flag;
   logic       serial_failure_flag, forced_sleep_status, uv_sleep_request, event_flags_clear, partial_network_clear;
   logic [1:0] can_mode_field;
   logic [7:0] mdl [128] = '{default: 8'h00};   // expected register contents
   int         mismatches = 0, compares = 0;
   srl_port #(.UVD_CYCLES(20)) dut (.clk_sys, .nrst, .serial_select_n, .sclk, .sdi, .sdo, .sdo_oe, .vcc_uv,
      .vio_uv, .normal_mode, .trx_active, .txd_dominant_timeout, .can_mode_field, .normal_sleep_entry,
      .bus_silence_event_enable, .can_failure_event_enable, .can_wakeup_event_enable, .wake_rising_edge_enable,
      .wake_falling_edge_enable, .can_failure_event_flag, .serial_failure_flag, .forced_sleep_status,
      .uv_sleep_request, .event_flags_clear, .partial_network_clear);
   srl_master mst (.clk_sys, .sdo, .serial_select_n, .sclk, .sdi);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // writable bits of each address, reserved bits read zero
   function automatic logic [7:0] msk(input logic [6:0] a);
      case (a)
         7'h06, 7'h07, 7'h08, 7'h09: return 8'hff;
         7'h0a: return 8'h7f;
         7'h04: return 8'h02;
         7'h23: return 8'h13;
         7'h4c: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction
   // address blocked by its lock bit
   function automatic bit blk(input logic [6:0] a);
      logic [7:0] l = mdl[10];
      return (a >= 7'h06 && a <= 7'h09 && l[0]) || (a[6:4] inside {[1:5]} && l[a[6:4]])
         || (a >= 7'h68 && a <= 7'h6f && l[6]);
   endfunction
   // one access of nb data bytes, sdo checked, model updated
   task automatic acc(input logic [6:0] a, input logic ro, input int nb, input logic [23:0] d);
      logic [39:0] q;
      logic [31:0] e;
      e = {8'h00, mdl[a], mdl[7'(a + 1)], mdl[7'(a + 2)]};
      mst.xfer(8 + 8 * nb, 40'({a, ro, d} >> (8 * (3 - nb))), q);
      chk(q, 40'(e >> (8 * (3 - nb))));
      for (int k = 0; k < nb; k++)
         if (!ro && int'(a) + k < 128 && !blk(7'(a + k)))
            mdl[7'(a + k)] = (mdl[7'(a + k)] & ~msk(7'(a + k))) | (d[23 - 8 * k -: 8] & msk(7'(a + k)));
   endtask
   initial begin
      #400_000;   // about four times the expected run length
      mismatches++;
      summarize;
   end
   initial begin
      logic [6:0]  a;
      logic [39:0] q, r;
      {nrst, vcc_uv, vio_uv, normal_mode, trx_active, txd_dominant_timeout, normal_sleep_entry} = '0;
      can_mode_field = 2'h0;
      void'($urandom(78743));
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk({sdo_oe, forced_sleep_status, serial_failure_flag, can_wakeup_event_enable}, 0);
      for (int i = 0; i < 14; i++) begin
         a = (i % 2) ? 7'(6 + $urandom_range(0, 3)) : 7'($urandom_range(0, 125));
         if (a inside {[7'h5f:7'h64]})
            a = 7'h07;
         acc(a, 1'($urandom), $urandom_range(1, 3), 24'($urandom));
      end
      acc(7'h0a, 0, 1, 24'hff0000);
      acc(7'h06, 0, 3, 24'h5a5a5a);
      acc(7'h23, 0, 1, 24'hff0000);
      acc(7'h0a, 0, 1, 24'h000000);
      acc(7'h23, 0, 2, 24'hffff00);
      acc(7'h4c, 0, 1, 24'hff0000);
      acc(7'h7f, 0, 3, 24'h123456);
      chk({bus_silence_event_enable, can_failure_event_enable, can_wakeup_event_enable}, 3'h7);
      chk({wake_rising_edge_enable, wake_falling_edge_enable}, 2'h3);
      acc(7'h04, 0, 1, 24'h020000);
      mst.xfer(20, 40'h0c5a5, q);
      chk(serial_failure_flag, 1);
      acc(7'h06, 1, 3, 24'h0);
      mdl[7'h61] = 8'h02;
      acc(7'h61, 0, 1, 24'h000000);
      chk(serial_failure_flag, 1);
      acc(7'h61, 0, 1, 24'h020000);
      chk(serial_failure_flag, 0);
      mst.xfer(12, 40'h0c5, q);
      r = {8'h0d, 32'($urandom)};
      mst.xfer(40, r, q);
      chk(q[7:0], r[7:0]);
      acc(7'h23, 0, 1, 24'h020000);
      {txd_dominant_timeout, trx_active} <= 2'h3;
      repeat (6) @(posedge clk_sys);
      chk(can_failure_event_flag, 0);
      normal_mode <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(can_failure_event_flag, 1);
      txd_dominant_timeout <= 1'b0;
      mdl[7'h63] = 8'h02;
      acc(7'h63, 0, 1, 24'h020000);
      chk(can_failure_event_flag, 0);
      {vcc_uv, can_mode_field} <= 3'h5;   // short supply dip in mode 01, too short to force sleep
      repeat (8) @(posedge clk_sys);
      chk(can_failure_event_flag, 1);
      {vcc_uv, can_mode_field} <= 3'h0;
      vio_uv <= 1'b1;
      repeat (40) @(posedge clk_sys);
      vio_uv <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk({forced_sleep_status, can_wakeup_event_enable, wake_rising_edge_enable, wake_falling_edge_enable,
         can_failure_event_flag, serial_failure_flag}, 6'h3c);
      {mdl[7'h03], mdl[7'h23], mdl[7'h4c]} = {8'h80, 8'h03, 8'h03};
      acc(7'h03, 1, 1, 24'h0);
      acc(7'h23, 1, 2, 24'h0);
      acc(7'h4c, 1, 1, 24'h0);
      normal_sleep_entry <= 1'b1;   // ordinary sleep entry drops the forced-sleep status
      repeat (2) @(posedge clk_sys);
      chk(forced_sleep_status, 0);
      summarize;
   end
endmodule
